// >>> verilog/rmsel_params.svh
// Offsets, field positions, reset values and counts of the reset and mode pin block
`ifndef RMSEL_PARAMS_SVH
`define RMSEL_PARAMS_SVH

`define RMSEL_OFF_SOPT   8'h00
`define RMSEL_OFF_CAUSE  8'h04
`define RMSEL_OFF_FORCE  8'h08
`define RMSEL_OFF_CTRL   8'h0c
`define RMSEL_OFF_MODE   8'h10
`define RMSEL_OFF_ISTAT  8'h14
`define RMSEL_OFF_IMASK  8'h18

`define RMSEL_SOPT_RESET_PIN_ENABLE 0
`define RMSEL_SOPT_DPE   1
`define RMSEL_CTRL_FAST  0
`define RMSEL_CTRL_EXTCK 1
`define RMSEL_FORCE_BIT  0
`define RMSEL_MODE_BDM   0
`define RMSEL_MODE_RST   1

`define RMSEL_CAUSE_POR  0
`define RMSEL_CAUSE_PIN  1
`define RMSEL_CAUSE_FRC  2
`define RMSEL_CAUSE_INT  3
`define RMSEL_CAUSE_W    4

`define RMSEL_CAUSE_RST  4'h1
`define RMSEL_PULSE_BUS  7'h42
`define RMSEL_POR_BUS    7'h08
`define RMSEL_BIT_DBGCLK 4'hf

`endif

// >>> verilog/rmsel_pkg.sv
// Types of the reset and mode pin block
`default_nettype none
package rmsel_pkg;

  typedef enum logic [1:0] {ST_POR, ST_PULSE, ST_RELEASE, ST_RUN} rmsel_state_e;

  typedef struct packed {
    rmsel_state_e state;
    logic [6:0]   cnt;
    logic         reset_pin_enable;
    logic         dpe;
    logic         fastClk;
    logic         extClk;
    logic         active_background_mode;
    logic [3:0]   cause;
    logic [3:0]   istat;
    logic [3:0]   imask;
    logic         dWr;
    logic         dRd;
    logic [7:0]   dAddr;
    logic         readyOut;
    logic         resp;
    logic [31:0]  rdata;
    logic         irq;
    logic         sysRst_n;
    logic         rpOut;
    logic         rpOe_n;
    logic         rpPull;
    logic         dlOut;
    logic         dlOe_n;
    logic         dlPull;
    logic         clkInt;
  } rmsel_main_s;

  typedef struct packed {
    logic       ph;
    logic [3:0] bitCnt;
    logic       busTick;
    logic       bitTick;
  } rmsel_div_s;

endpackage
`default_nettype wire

// >>> verilog/rmsel_clk_div.sv
// Bus clock enable and debug bit-time enable divider
`timescale 1ns/1ps
`default_nettype none
`include "rmsel_params.svh"
module rmsel_clk_div (
  input  wire logic clk,      // Clock generator output, 20 MHz
  input  wire logic rst_n,    // Asynchronous reset, active low
  input  wire logic fastSel,  // Debug clock taken from the fast clock
  output logic      busTick,  // Bus clock enable, every second clk
  output logic      bitTick   // One debug bit time elapsed
);
  import rmsel_pkg::*;

  rmsel_div_s s_reg;
  rmsel_div_s s_next;
  logic       dbgTick;

  always_comb begin
    s_next = s_reg;
    dbgTick = fastSel ? 1'b1 : s_reg.ph;
    s_next.ph = ~s_reg.ph;
    s_next.busTick = s_reg.ph;
    s_next.bitTick = dbgTick && (s_reg.bitCnt == `RMSEL_BIT_DBGCLK);
    if (dbgTick) begin
      s_next.bitCnt = s_reg.bitCnt + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busTick = s_reg.busTick;
  assign bitTick = s_reg.bitTick;

endmodule // rmsel_clk_div
`default_nettype wire

// >>> verilog/rmsel_top.sv
// Reset pin, background/mode-select pin and reset cause logic with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "rmsel_params.svh"
module rmsel_top (
  input  wire logic        clk,            // Clock generator output, 20 MHz
  input  wire logic        rst_n,          // Power-on reset, active low
  input  wire logic        hsel,           // AHB slave select
  input  wire logic [31:0] haddr,          // AHB address
  input  wire logic [1:0]  htrans,         // AHB transfer type
  input  wire logic        hwrite,         // AHB write
  input  wire logic [2:0]  hsize,          // AHB size, word only
  input  wire logic [31:0] hwdata,         // AHB write data
  input  wire logic        hready,         // AHB bus ready
  output logic [31:0]      hrdata,         // AHB read data
  output logic             hreadyout,      // AHB slave ready
  output logic             hresp,          // AHB response, always OKAY
  input  wire logic        resetPinIn,     // Shared reset pin level
  output logic             resetPinOut,    // Shared reset pin drive value
  output logic             resetPinOe_n,   // Shared reset pin enable, low drives
  output logic             resetPinPullUp, // Reset pin pull-up enable
  input  wire logic        gpioA5Out,      // Port bit 5 output value
  input  wire logic        gpioA5OutEn,    // Port bit 5 output enable
  input  wire logic        dbgLineIn,      // Debug line level
  output logic             dbgLineOut,     // Debug line drive value
  output logic             dbgLineOe_n,    // Debug line enable, low drives
  output logic             dbgLinePullUp,  // Debug line pull-up enable
  input  wire logic        dbgDriveLow,    // Debug controller pulls line low
  input  wire logic        dbgSpeedup,     // Debug controller speed-up pulse
  input  wire logic        altA4Out,       // Port bit 4 or comparator value
  input  wire logic        altA4OutEn,     // Port bit 4 or comparator enable
  input  wire logic        intResetReq,    // Internal reset source request
  output logic             sysReset_n,     // Chip reset, active low
  output logic             backgroundMode, // Active background mode
  output logic             clkInternalSel, // Internal clock generator selected
  output logic             busClkEn,       // Bus clock enable pulse
  output logic             dbgBitTick,     // Debug bit time pulse
  output logic             irq             // Interrupt, level
);
  import rmsel_pkg::*;

  rmsel_main_s s_reg;
  rmsel_main_s s_next;
  logic        busTick;
  logic        bitTick;
  logic        addrOk;
  logic        wrNow;
  logic        forceHit;
  logic        pinHit;
  logic [3:0]  trig;

  function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
    regHit = (a == off);
  endfunction

  function automatic logic [31:0] regRead(input rmsel_main_s s);
    regRead = 32'h0;
    if (regHit(s.dAddr, `RMSEL_OFF_SOPT)) begin
      regRead[`RMSEL_SOPT_RESET_PIN_ENABLE] = s.reset_pin_enable;
      regRead[`RMSEL_SOPT_DPE] = s.dpe;
    end
    if (regHit(s.dAddr, `RMSEL_OFF_CAUSE)) begin
      regRead[3:0] = s.cause;
    end
    if (regHit(s.dAddr, `RMSEL_OFF_CTRL)) begin
      regRead[`RMSEL_CTRL_FAST] = s.fastClk;
      regRead[`RMSEL_CTRL_EXTCK] = s.extClk;
    end
    if (regHit(s.dAddr, `RMSEL_OFF_MODE)) begin
      regRead[`RMSEL_MODE_BDM] = s.active_background_mode;
      regRead[`RMSEL_MODE_RST] = ~s.sysRst_n;
    end
    if (regHit(s.dAddr, `RMSEL_OFF_ISTAT)) begin
      regRead[3:0] = s.istat;
    end
    if (regHit(s.dAddr, `RMSEL_OFF_IMASK)) begin
      regRead[3:0] = s.imask;
    end
  endfunction

  rmsel_clk_div u_div (
    .clk     (clk),
    .rst_n   (rst_n),
    .fastSel (s_reg.fastClk),
    .busTick (busTick),
    .bitTick (bitTick)
  );

  always_comb begin
    s_next = s_reg;
    addrOk = hsel && htrans[1] && hready;
    wrNow = s_reg.dWr;
    forceHit = wrNow && regHit(s_reg.dAddr, `RMSEL_OFF_FORCE) && hwdata[`RMSEL_FORCE_BIT];
    // The pin only counts as a reset source once its enable bit is set
    pinHit = s_reg.reset_pin_enable && !resetPinIn;
    trig = 4'h0;

    // Bus data phase
    s_next.dWr = 1'b0;
    if (s_reg.dRd && !s_reg.readyOut) begin
      s_next.rdata = regRead(s_reg);
      s_next.readyOut = 1'b1;
      s_next.dRd = 1'b0;
    end
    if (addrOk) begin
      s_next.dAddr = haddr[7:0];
      s_next.dWr = hwrite;
      s_next.dRd = !hwrite;
      s_next.readyOut = hwrite;
    end
    if (wrNow && regHit(s_reg.dAddr, `RMSEL_OFF_SOPT)) begin
      // Enable bit can only be set; only power-on clears it
      s_next.reset_pin_enable = s_reg.reset_pin_enable | hwdata[`RMSEL_SOPT_RESET_PIN_ENABLE];
      s_next.dpe = hwdata[`RMSEL_SOPT_DPE];
    end
    if (wrNow && regHit(s_reg.dAddr, `RMSEL_OFF_CTRL)) begin
      s_next.fastClk = hwdata[`RMSEL_CTRL_FAST];
      s_next.extClk = hwdata[`RMSEL_CTRL_EXTCK];
    end
    if (wrNow && regHit(s_reg.dAddr, `RMSEL_OFF_IMASK)) begin
      s_next.imask = hwdata[3:0];
    end
    if (wrNow && regHit(s_reg.dAddr, `RMSEL_OFF_ISTAT)) begin
      s_next.istat = s_reg.istat & ~hwdata[3:0];
    end

    // Reset sequencer
    case (s_reg.state)
      // Mode is sampled on the last bus tick, while the debug line is still released
      ST_POR: begin
        if (busTick) begin
          s_next.cnt = s_reg.cnt + 7'h01;
          if (s_reg.cnt == `RMSEL_POR_BUS - 7'h01) begin
            s_next.active_background_mode = !dbgLineIn;
            s_next.state = ST_RUN;
          end
        end
      end
      ST_PULSE: begin
        if (busTick) begin
          s_next.cnt = s_reg.cnt + 7'h01;
          if (s_reg.cnt == `RMSEL_PULSE_BUS - 7'h01) begin
            s_next.state = ST_RELEASE;
          end
        end
      end
      ST_RELEASE: begin
        // Stay in reset while an outside source still holds the pin low
        if (!pinHit) begin
          s_next.active_background_mode = s_reg.cause[`RMSEL_CAUSE_FRC] && !dbgLineIn;
          s_next.state = ST_RUN;
        end
      end
      // One cause per reset; a force write outranks the pin and the internal source
      ST_RUN: begin
        if (forceHit) begin
          trig[`RMSEL_CAUSE_FRC] = 1'b1;
        end else if (pinHit) begin
          trig[`RMSEL_CAUSE_PIN] = 1'b1;
        end else if (intResetReq) begin
          trig[`RMSEL_CAUSE_INT] = 1'b1;
        end
        if (|trig) begin
          s_next.state = ST_PULSE;
          s_next.cnt = 7'h00;
          s_next.cause = trig;
          s_next.active_background_mode = 1'b0;
          s_next.dpe = 1'b1;
          s_next.fastClk = 1'b0;
          s_next.extClk = 1'b0;
        end
      end
      default: begin
        s_next.state = ST_POR;
      end
    endcase
    // A new cause wins over a clear in the same cycle
    s_next.istat = s_next.istat | trig;

    // Chip reset and pin outputs come from the same flop update as the state,
    // so no output lags the sequencer by a cycle
    s_next.sysRst_n = (s_next.state == ST_RUN);
    s_next.clkInt = !s_next.extClk || !s_next.sysRst_n;
    s_next.irq = |(s_next.istat & s_next.imask);

    // Shared reset pin
    s_next.rpOut = 1'b0;
    s_next.rpOe_n = 1'b1;
    s_next.rpPull = s_next.reset_pin_enable;
    if (s_next.reset_pin_enable) begin
      s_next.rpOe_n = !(s_next.state == ST_PULSE);
    end else if (gpioA5OutEn) begin
      s_next.rpOut = gpioA5Out;
      s_next.rpOe_n = 1'b0;
    end

    // Shared debug pin, left undriven in reset so mode can be sampled
    s_next.dlOut = 1'b0;
    s_next.dlOe_n = 1'b1;
    s_next.dlPull = s_next.dpe;
    if (s_next.sysRst_n) begin
      if (s_next.dpe) begin
        // Speed-up pulse wins so a rising edge is never held low
        if (dbgSpeedup) begin
          s_next.dlOut = 1'b1;
          s_next.dlOe_n = 1'b0;
        end else if (dbgDriveLow) begin
          s_next.dlOe_n = 1'b0;
        end
      end else if (altA4OutEn) begin
        s_next.dlOut = altA4Out;
        s_next.dlOe_n = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.dpe <= 1'b1;
      s_reg.cause <= `RMSEL_CAUSE_RST;
      s_reg.istat <= `RMSEL_CAUSE_RST;
      s_reg.readyOut <= 1'b1;
      s_reg.rpOe_n <= 1'b1;
      s_reg.dlOe_n <= 1'b1;
      s_reg.dlPull <= 1'b1;
      s_reg.clkInt <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hrdata = s_reg.rdata;
  assign hreadyout = s_reg.readyOut;
  assign hresp = s_reg.resp;
  assign resetPinOut = s_reg.rpOut;
  assign resetPinOe_n = s_reg.rpOe_n;
  assign resetPinPullUp = s_reg.rpPull;
  assign dbgLineOut = s_reg.dlOut;
  assign dbgLineOe_n = s_reg.dlOe_n;
  assign dbgLinePullUp = s_reg.dlPull;
  assign sysReset_n = s_reg.sysRst_n;
  assign backgroundMode = s_reg.active_background_mode;
  assign clkInternalSel = s_reg.clkInt;
  assign busClkEn = busTick;
  assign dbgBitTick = bitTick;
  assign irq = s_reg.irq;

  // Helper: clk cycles spent in the pulse state
  logic [8:0] pulseClk;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulseClk <= 9'h000;
    end else if (s_reg.state == ST_PULSE) begin
      pulseClk <= pulseClk + 9'h001;
    end else begin
      pulseClk <= 9'h000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_bus_half: assert property (busClkEn |=> !busClkEn ##1 busClkEn)
    else $error("bus enable not every second clock");
  a_pin_gpio_only: assert property (!s_reg.reset_pin_enable && !resetPinOe_n |-> $past(gpioA5OutEn))
    else $error("reset pin driven while a port bit without enable");
  a_reset_pin_enable_sticky: assert property (s_reg.reset_pin_enable |=> s_reg.reset_pin_enable && resetPinPullUp)
    else $error("reset pin enable lost");
  a_pin_resets: assert property (s_reg.state == ST_RUN && pinHit && !forceHit
                                 |=> s_reg.state == ST_PULSE ##1 !sysReset_n)
    else $error("pin low did not reset");
  a_pulse_len: assert property ($fell(s_reg.state == ST_PULSE)
                                |-> pulseClk >= 9'h083 && pulseClk <= 9'h084)
    else $error("reset pulse length wrong");
  a_cause_onehot: assert property (s_reg.state == ST_PULSE |-> $onehot(s_reg.cause))
    else $error("reset cause not one-hot");
  a_dbg_quiet: assert property (!sysReset_n |-> dbgLineOe_n)
    else $error("debug line driven during reset");
  a_dpe_pullup: assert property (s_reg.state != ST_RUN |-> s_reg.dpe ##1 dbgLinePullUp)
    else $error("debug pin enable or pull-up missing in reset");
  a_pin_user_mode: assert property (s_reg.state == ST_RUN && s_reg.cause[`RMSEL_CAUSE_PIN]
                                    |-> !backgroundMode)
    else $error("pin reset entered background mode");
  a_clk_internal: assert property (!sysReset_n |-> clkInternalSel)
    else $error("external clock in reset");

  // Pin and mode outputs are registered with the state, so they must agree in one cycle
  a_pulse_drive: assert property (s_reg.reset_pin_enable && s_reg.state == ST_PULSE
                                  |-> !resetPinOe_n && !resetPinOut)
    else $error("reset pin not driven low in pulse");
  a_release_hold: assert property (s_reg.state == ST_RELEASE && pinHit
                                   |=> s_reg.state == ST_RELEASE && !sysReset_n)
    else $error("reset released while pin still low");
  a_pulse_no_bdm: assert property (s_reg.state == ST_PULSE |-> !backgroundMode)
    else $error("background mode kept during reset pulse");
  a_dbg_pull: assert property (dbgLinePullUp == s_reg.dpe)
    else $error("debug line pull-up does not follow enable");
  a_speedup_high: assert property (sysReset_n && s_reg.dpe && !dbgLineOe_n
                                   |-> dbgLineOut == $past(dbgSpeedup))
    else $error("debug line drive value wrong");
  a_force_first: assert property (s_reg.state == ST_RUN && forceHit
                                  |=> s_reg.cause[`RMSEL_CAUSE_FRC])
    else $error("force write not recorded as cause");
  a_istat_set: assert property (|trig |=> (s_reg.istat & $past(trig)) == $past(trig))
    else $error("reset cause not latched in status");

  // Bus side: one wait state on reads, level interrupt from registered status
  a_read_wait: assert property (s_reg.dRd && !hreadyout |=> hreadyout && !s_reg.dRd)
    else $error("read answer not given after one wait state");
  a_irq_level: assert property (irq == |(s_reg.istat & s_reg.imask))
    else $error("interrupt does not follow status and mask");

  c_pin_reset: cover property (s_reg.state == ST_RUN ##1 s_reg.cause[`RMSEL_CAUSE_PIN]);
  c_force_bdm: cover property (s_reg.cause[`RMSEL_CAUSE_FRC] && $rose(backgroundMode));
  c_int_reset: cover property ($rose(s_reg.cause[`RMSEL_CAUSE_INT]));
  c_irq: cover property ($rose(irq));
  c_speedup: cover property (!dbgLineOe_n && dbgLineOut);

endmodule // rmsel_top
`default_nettype wire

// >>> sim/rmsel_partner.sv
// Model of the external reset source and debug host on the shared pins
`timescale 1ns/1ps
`default_nettype none
module rmsel_partner (
  input  wire logic clk,     // Bench clock
  input  wire logic pullLow, // Reset source pulls the reset pin low
  input  wire logic msLow,   // Debug host holds mode select low
  input  wire logic rpOut,   // Device reset pin value
  input  wire logic rpOe_n,  // Device reset pin enable, low drives
  input  wire logic rpPull,  // Device reset pin pull-up
  input  wire logic dlOut,   // Device debug line value
  input  wire logic dlOe_n,  // Device debug line enable, low drives
  input  wire logic dlPull,  // Device debug line pull-up
  output logic      rpLevel, // Reset pin level
  output logic      dlLevel  // Debug line level
);
  logic flt = 1'b0;
  // A floating line toggles so that it never settles to a friendly value
  always @(posedge clk) flt <= ~flt;
  always_comb begin
    // Outside parties only ever pull low, never drive high
    rpLevel = !rpOe_n ? rpOut : pullLow ? 1'b0 : rpPull ? 1'b1 : flt;
    dlLevel = !dlOe_n ? dlOut : msLow ? 1'b0 : dlPull ? 1'b1 : flt;
  end
endmodule // rmsel_partner
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench of the reset and mode pin block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) chk(n, 32'(e), 32'(s))
module testbench;
  logic        clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic        rpOut, rpOe_n, rpPull, dlOut, dlOe_n, dlPull, rpLevel, dlLevel;
  logic        a5, a5En, a4, a4En, drvLow, spdUp, intReq, sysRst_n, bgMode;
  logic        clkInt, busEn, bitTick, irq, pullLow, msLow, rdPend = 1'b0;
  logic [31:0] expQ[$];
  string       nameQ[$];
  int          fails, n_checks, seed, g;

  rmsel_top DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .resetPinIn(rpLevel), .resetPinOut(rpOut),
    .resetPinOe_n(rpOe_n), .resetPinPullUp(rpPull), .gpioA5Out(a5), .gpioA5OutEn(a5En),
    .dbgLineIn(dlLevel), .dbgLineOut(dlOut), .dbgLineOe_n(dlOe_n), .dbgLinePullUp(dlPull),
    .dbgDriveLow(drvLow), .dbgSpeedup(spdUp), .altA4Out(a4), .altA4OutEn(a4En),
    .intResetReq(intReq), .sysReset_n(sysRst_n), .backgroundMode(bgMode),
    .clkInternalSel(clkInt), .busClkEn(busEn), .dbgBitTick(bitTick), .irq(irq));

  rmsel_partner u_far (.clk(clk), .pullLow(pullLow), .msLow(msLow), .rpOut(rpOut),
    .rpOe_n(rpOe_n), .rpPull(rpPull), .dlOut(dlOut), .dlOe_n(dlOe_n), .dlPull(dlPull),
    .rpLevel(rpLevel), .dlLevel(dlLevel));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic summarize;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Address phase held until ready, then data phase held until ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    nameQ.push_back($sformatf("rd%h", a));
    bus(1'b0, a, 32'h0);
  endtask

  task automatic waitRun;
    int i;
    i = 0;
    while (sysRst_n !== 1'b1 && i < 3000) begin @(posedge clk); i++; end
    `CHK("run", 1'b1, sysRst_n);
  endtask

  // Cycles between two successive pulses of a tick output
  task automatic gap(input bit s, output int n);
    int i;
    i = 0;
    while ((s ? busEn : bitTick) !== 1'b1 && i < 100) begin @(posedge clk); i++; end
    @(posedge clk);
    n = 1;
    while ((s ? busEn : bitTick) !== 1'b1 && n < 100) begin @(posedge clk); n++; end
  endtask

  task automatic pulse(input string n);
    int i;
    i = 0;
    while (rpOe_n !== 1'b0 && i < 50) begin @(posedge clk); i++; end
    i = 0;
    while (rpOe_n === 1'b0 && i < 400) begin @(posedge clk); i++; end
    `CHK(n, 1'b1, i >= 130 && i <= 133);
  endtask

  // Read answers are compared when the data phase completes
  always @(posedge clk) begin
    if (rdPend && hreadyout === 1'b1) begin
      `CHK(nameQ.pop_front(), expQ.pop_front(), hrdata);
      `CHK("hresp", 1'b0, hresp);
    end
    if (hreadyout === 1'b1) rdPend <= hsel && htrans[1] && !hwrite;
  end

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    summarize;
  end

  initial begin
    seed = 49187; fails = 0; n_checks = 0; rst_n = 1'b0;
    hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0; htrans = 2'b00;
    a5 = 1'b0; a5En = 1'b0; a4 = 1'b0; a4En = 1'b0; drvLow = 1'b0; spdUp = 1'b0;
    intReq = 1'b0; pullLow = 1'b0; msLow = 1'b0;
    cyc(20);
    `CHK("rpOe", 1'b1, rpOe_n);
    `CHK("dlPull", 1'b1, dlPull);
    `CHK("sysRst", 1'b0, sysRst_n);
    rst_n <= 1'b1;
    waitRun;
    `CHK("bg", 1'b0, bgMode);
    `CHK("clkInt", 1'b1, clkInt);
    `CHK("rpPull", 1'b0, rpPull);
    rd(8'h04, 32'h1);
    rd(8'h00, 32'h2);
    rd(8'h20, 32'h0);
    repeat (4) begin
      a5 <= 1'($random(seed)); a5En <= 1'b1;
      cyc(3);
      `CHK("a5", {1'b0, a5}, {rpOe_n, rpOut});
    end
    a5En <= 1'b0;
    wr(8'h18, 32'h0); cyc(2);
    `CHK("irqMask", 1'b0, irq);
    wr(8'h18, 32'hf); cyc(2);
    `CHK("irqSet", 1'b1, irq);
    wr(8'h14, 32'h1); rd(8'h14, 32'h0); cyc(1);
    `CHK("irqClr", 1'b0, irq);
    gap(1'b1, g);
    `CHK("busGap", 2, g);
    gap(1'b0, g); gap(1'b0, g);
    `CHK("bitGap", 32, g);
    wr(8'h0c, 32'h1); gap(1'b0, g); gap(1'b0, g);
    `CHK("fastGap", 16, g);
    wr(8'h0c, 32'h2); cyc(3);
    `CHK("extClk", 1'b0, clkInt);
    wr(8'h00, 32'h3); wr(8'h00, 32'h2); rd(8'h00, 32'h3);
    `CHK("rpPullEn", 1'b1, rpPull);
    // Pin reset with mode select low must still end in user mode
    msLow <= 1'b1; pullLow <= 1'b1;
    fork
      begin cyc(3); pullLow <= 1'b0; end
      pulse("pinPulse");
    join
    waitRun; msLow <= 1'b0;
    `CHK("bgPin", 1'b0, bgMode);
    rd(8'h04, 32'h2);
    rd(8'h14, 32'h2);
    wr(8'h14, 32'h2);
    for (int k = 0; k < 3; k++) begin
      spdUp <= (k == 0); drvLow <= (k == 1);
      cyc(3);
      `CHK("dlOe", k == 2, dlOe_n);
      if (k < 2) `CHK("dlOut", k == 0, dlOut);
    end
    spdUp <= 1'b0; drvLow <= 1'b0;
    wr(8'h00, 32'h0); a4 <= 1'($random(seed)); a4En <= 1'b1; cyc(3);
    `CHK("dlPullOff", 1'b0, dlPull);
    `CHK("a4", {1'b0, a4}, {dlOe_n, dlOut});
    msLow <= 1'b1; wr(8'h08, 32'h1); pulse("frcPulse"); waitRun; msLow <= 1'b0;
    `CHK("bgFrc", 1'b1, bgMode);
    rd(8'h04, 32'h4);
    rd(8'h00, 32'h3);
    rd(8'h10, 32'h1);
    wr(8'h08, 32'h1); pulse("frc2Pulse"); waitRun;
    `CHK("bgNorm", 1'b0, bgMode);
    wr(8'h0c, 32'h3); intReq <= 1'b1; cyc(1); intReq <= 1'b0;
    pulse("intPulse"); waitRun;
    rd(8'h04, 32'h8);
    rd(8'h0c, 32'h0);
    `CHK("clkIntRst", 1'b1, clkInt);
    // Second power-on with the host holding mode select low
    msLow <= 1'b1; rst_n <= 1'b0; cyc(20);
    `CHK("rpPullPor", 1'b0, rpPull);
    rst_n <= 1'b1; waitRun; msLow <= 1'b0;
    `CHK("bgPor", 1'b1, bgMode);
    rd(8'h04, 32'h1);
    rd(8'h00, 32'h2);
    cyc(2);
    summarize;
  end
endmodule // testbench
`default_nettype wire
